/* File: src/htc_pkg.sv */
// Field layout, encodings and carriers of the host translation control
package htc_pkg;

  // ==========================================================
  // Register geometry
  localparam int REG_W = 64;
  // Writable bits 42..0 except reserved bits 35 and 6
  localparam logic [63:0] WRITE_MASK   = 64'h0000_07F7_FFFF_FFBF;
  localparam logic [63:0] RESET_VALUE  = 64'h0000_0000_0000_0000;

  // ==========================================================
  // Field positions
  localparam int POS_UPPER_HPD   = 42;
  localparam int POS_LOWER_HPD   = 41;
  localparam int POS_DIRTY_EN    = 40;
  localparam int POS_AF_EN       = 39;
  localparam int POS_UPPER_TBI   = 38;
  localparam int POS_LOWER_TBI   = 37;
  localparam int POS_ID_WIDTH    = 36;
  localparam int POS_IPS_LO      = 32;
  localparam int POS_UPPER_TG_LO = 30;
  localparam int POS_UPPER_SH_LO = 28;
  localparam int POS_UPPER_OC_LO = 26;
  localparam int POS_UPPER_IC_LO = 24;
  localparam int POS_UPPER_EPD   = 23;
  localparam int POS_ASID_SEL    = 22;
  localparam int POS_UPPER_SZ_LO = 16;
  localparam int POS_LOWER_TG_LO = 14;
  localparam int POS_LOWER_SH_LO = 12;
  localparam int POS_LOWER_OC_LO = 10;
  localparam int POS_LOWER_IC_LO = 8;
  localparam int POS_LOWER_EPD   = 7;
  localparam int POS_LOWER_SZ_LO = 0;

  // ==========================================================
  // Address tag and ASID geometry
  localparam int TAG_HI       = 63;
  localparam int TAG_LO       = 56;
  localparam int TAG_SEL_BIT  = 55;
  localparam int ASID_W       = 16;
  localparam int ASID_NARROW  = 8;
  localparam logic [6:0] VA_FULL_BITS = 7'h40;

  // ==========================================================
  // Physical size encodings and widths in bits
  localparam logic [2:0] IPS_32 = 3'h0;
  localparam logic [2:0] IPS_36 = 3'h1;
  localparam logic [2:0] IPS_40 = 3'h2;
  localparam logic [2:0] IPS_42 = 3'h3;
  localparam logic [2:0] IPS_44 = 3'h4;
  localparam logic [5:0] PA_BITS_32 = 6'h20;
  localparam logic [5:0] PA_BITS_36 = 6'h24;
  localparam logic [5:0] PA_BITS_40 = 6'h28;
  localparam logic [5:0] PA_BITS_42 = 6'h2A;
  localparam logic [5:0] PA_BITS_44 = 6'h2C;
  localparam logic [5:0] PA_BITS_48 = 6'h30;

  // Granule encodings of each region
  localparam logic [1:0] LOWER_TG_4K  = 2'h0;
  localparam logic [1:0] LOWER_TG_64K = 2'h1;
  localparam logic [1:0] LOWER_TG_16K = 2'h2;
  localparam logic [1:0] UPPER_TG_16K = 2'h1;
  localparam logic [1:0] UPPER_TG_4K  = 2'h2;
  localparam logic [1:0] UPPER_TG_64K = 2'h3;

  // Shareability encodings
  localparam logic [1:0] SH_NON   = 2'h0;
  localparam logic [1:0] SH_OUTER = 2'h2;
  localparam logic [1:0] SH_INNER = 2'h3;

  // ==========================================================
  // Decoded types
  typedef enum logic [1:0] {
    HTC_GRAN_4K,
    HTC_GRAN_16K,
    HTC_GRAN_64K
  } htc_granule_type;

  typedef enum logic [1:0] {
    HTC_SHARE_NON,
    HTC_SHARE_OUTER,
    HTC_SHARE_INNER
  } htc_share_type;

  typedef enum logic [1:0] {
    HTC_CACHE_NC,
    HTC_CACHE_WBWA,
    HTC_CACHE_WT,
    HTC_CACHE_WBNWA
  } htc_cache_type;

  // Walk attributes of one region
  typedef struct packed {
    htc_granule_type granule;
    htc_share_type   share;
    htc_cache_type   outer_cache;
    htc_cache_type   inner_cache;
    logic [6:0]      size_log2;
    logic            hier_perm_disable;
    logic            walk_disable;
    logic            top_byte_ignore;
  } htc_walk_attr_type;

  // Regime-wide controls
  typedef struct packed {
    logic       access_flag_update_en;
    logic       dirty_state_hw_en;
    logic       wide_asid;
    logic [5:0] pa_bits;
  } htc_regime_type;

endpackage

/* File: src/htc_pc_tag_fix.sv */
// Program counter top-byte fixup for tagged target addresses
`timescale 1ns/10ps
`default_nettype none

module htc_pc_tag_fix (
  input  wire logic [63:0] target_i,      // Branch or exception target
  input  wire logic        lower_tbi_i,   // Lower region tag ignore
  input  wire logic        upper_tbi_i,   // Upper region tag ignore
  output logic      [63:0] pc_value_o     // Value to load into the PC
);

  // ==========================================================
  // Tag byte forced from bit 55 when that region ignores tags
  always_comb begin
    pc_value_o = target_i;
    if (target_i[htc_pkg::TAG_SEL_BIT] && upper_tbi_i) begin
      pc_value_o[htc_pkg::TAG_HI:htc_pkg::TAG_LO] = 8'hFF;
    end else if (!target_i[htc_pkg::TAG_SEL_BIT] && lower_tbi_i) begin
      pc_value_o[htc_pkg::TAG_HI:htc_pkg::TAG_LO] = 8'h00;
    end
  end

endmodule

`default_nettype wire

/* File: src/htc_ctrl.sv */
// Host translation control register with decode and lookup support
`timescale 1ns/10ps
`default_nettype none

module htc_ctrl #(
  parameter bit HAS_ACCESS_FLAG = 1'b1,  // Access-flag update implemented
  parameter bit HAS_DIRTY_STATE = 1'b1,  // Dirty-state management implemented
  parameter bit HAS_WIDE_ASID   = 1'b1,  // 16-bit ASIDs implemented
  parameter bit HAS_GRAN_16K    = 1'b1,  // 16KB granule implemented
  parameter bit HAS_GRAN_64K    = 1'b1   // 64KB granule implemented
) (
  input  wire logic                  mclk_i,              // Clock
  input  wire logic                  reset_i,             // Async reset
  input  wire logic                  host_extension_ctrl_i, // Host layout on
  input  wire logic                  sreg_wr_i,           // Register write
  input  wire logic [63:0]           sreg_wdata_i,        // Write data
  output logic      [63:0]           sreg_rdata_o,        // Read data
  input  wire logic [15:0]           lower_asid_i,        // Lower base ASID
  input  wire logic [15:0]           upper_asid_i,        // Upper base ASID
  output logic      [15:0]           active_asid_o,       // ASID for TLB
  input  wire logic                  lookup_valid_i,      // Lookup request
  input  wire logic [63:0]           lookup_addr_i,       // Lookup address
  input  wire logic                  lookup_miss_i,       // TLB missed
  output logic                       lookup_done_o,       // Lookup answer
  output logic                       lookup_upper_o,      // Upper region
  output logic      [63:0]           match_addr_o,        // Address to match
  output logic                       walk_req_o,          // Start walk
  output logic                       trans_fault_o,       // Translation fault
  output htc_pkg::htc_walk_attr_type walk_attr_o,         // Region attributes
  output htc_pkg::htc_regime_type    regime_o,            // Regime controls
  input  wire logic                  pc_load_i,           // PC load request
  input  wire logic [63:0]           pc_target_i,         // PC target
  output logic                       pc_load_o,           // PC load strobe
  output logic      [63:0]           pc_value_o           // Fixed PC value
);

  // ==========================================================
  // Parameter checks
  // Ports are fixed at 64 and 16 bits; package geometry must agree
  if (htc_pkg::REG_W != 64 || htc_pkg::ASID_W != 16) begin : g_bad_cfg
    $error("register or ASID width differs from the port widths");
  end


  // ==========================================================
  // Implemented-bit mask
  logic [63:0] impl_mask;

  // Optional bits dropped from the writable set
  always_comb begin
    impl_mask = htc_pkg::WRITE_MASK;
    impl_mask[htc_pkg::POS_AF_EN]    = HAS_ACCESS_FLAG;
    impl_mask[htc_pkg::POS_DIRTY_EN] = HAS_DIRTY_STATE;
    impl_mask[htc_pkg::POS_ID_WIDTH] = HAS_WIDE_ASID;
  end

  // ==========================================================
  // Control register
  logic [63:0] ctrl_q;
  logic [63:0] ctrl_d;

  // Masked write; readback keeps programmed granule values
  always_comb begin
    ctrl_d = ctrl_q;
    if (sreg_wr_i) begin
      ctrl_d = sreg_wdata_i & impl_mask;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= htc_pkg::RESET_VALUE;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign sreg_rdata_o = ctrl_q;

  // ==========================================================
  // Field extraction
  logic [1:0] upper_tg;
  logic [1:0] lower_tg;
  logic [1:0] upper_sh;
  logic [1:0] lower_sh;
  logic [2:0] intermediate_phys_size;

  assign upper_tg = ctrl_q[htc_pkg::POS_UPPER_TG_LO +: 2];
  assign lower_tg = ctrl_q[htc_pkg::POS_LOWER_TG_LO +: 2];
  assign upper_sh = ctrl_q[htc_pkg::POS_UPPER_SH_LO +: 2];
  assign lower_sh = ctrl_q[htc_pkg::POS_LOWER_SH_LO +: 2];
  assign intermediate_phys_size      = ctrl_q[htc_pkg::POS_IPS_LO +: 3];

  // ==========================================================
  // Decode helpers
  function automatic htc_pkg::htc_granule_type gran_fit(
    input htc_pkg::htc_granule_type want
  );
    gran_fit = want;
    if ((want == htc_pkg::HTC_GRAN_16K && !HAS_GRAN_16K) ||
        (want == htc_pkg::HTC_GRAN_64K && !HAS_GRAN_64K)) begin
      gran_fit = htc_pkg::HTC_GRAN_4K;
    end
  endfunction

  function automatic htc_pkg::htc_share_type share_dec(
    input logic [1:0] code
  );
    if (code == htc_pkg::SH_OUTER) begin
      share_dec = htc_pkg::HTC_SHARE_OUTER;
    end else if (code == htc_pkg::SH_INNER) begin
      share_dec = htc_pkg::HTC_SHARE_INNER;
    end else begin
      share_dec = htc_pkg::HTC_SHARE_NON;
    end
  endfunction

  function automatic logic [6:0] size_dec(input logic [5:0] offset);
    size_dec = htc_pkg::VA_FULL_BITS - {1'b0, offset};
  endfunction

  // ==========================================================
  // Per-region attribute decode
  htc_pkg::htc_walk_attr_type upper_attr;
  htc_pkg::htc_walk_attr_type lower_attr;
  htc_pkg::htc_granule_type   upper_gran;
  htc_pkg::htc_granule_type   lower_gran;

  // Granule codes differ between the two regions
  always_comb begin
    case (upper_tg)
      htc_pkg::UPPER_TG_16K: upper_gran = htc_pkg::HTC_GRAN_16K;
      htc_pkg::UPPER_TG_4K:  upper_gran = htc_pkg::HTC_GRAN_4K;
      htc_pkg::UPPER_TG_64K: upper_gran = htc_pkg::HTC_GRAN_64K;
      default:               upper_gran = htc_pkg::HTC_GRAN_4K;
    endcase
    case (lower_tg)
      htc_pkg::LOWER_TG_4K:  lower_gran = htc_pkg::HTC_GRAN_4K;
      htc_pkg::LOWER_TG_64K: lower_gran = htc_pkg::HTC_GRAN_64K;
      htc_pkg::LOWER_TG_16K: lower_gran = htc_pkg::HTC_GRAN_16K;
      default:               lower_gran = htc_pkg::HTC_GRAN_4K;
    endcase
  end

  // Attribute bundles for each region
  always_comb begin
    upper_attr.granule     = gran_fit(upper_gran);
    upper_attr.share       = share_dec(upper_sh);
    upper_attr.outer_cache = htc_pkg::htc_cache_type'(
      ctrl_q[htc_pkg::POS_UPPER_OC_LO +: 2]);
    upper_attr.inner_cache = htc_pkg::htc_cache_type'(
      ctrl_q[htc_pkg::POS_UPPER_IC_LO +: 2]);
    upper_attr.size_log2   = size_dec(
      ctrl_q[htc_pkg::POS_UPPER_SZ_LO +: 6]);
    upper_attr.hier_perm_disable = ctrl_q[htc_pkg::POS_UPPER_HPD];
    upper_attr.walk_disable      = ctrl_q[htc_pkg::POS_UPPER_EPD];
    upper_attr.top_byte_ignore   = ctrl_q[htc_pkg::POS_UPPER_TBI];
    lower_attr.granule     = gran_fit(lower_gran);
    lower_attr.share       = share_dec(lower_sh);
    lower_attr.outer_cache = htc_pkg::htc_cache_type'(
      ctrl_q[htc_pkg::POS_LOWER_OC_LO +: 2]);
    lower_attr.inner_cache = htc_pkg::htc_cache_type'(
      ctrl_q[htc_pkg::POS_LOWER_IC_LO +: 2]);
    lower_attr.size_log2   = size_dec(
      ctrl_q[htc_pkg::POS_LOWER_SZ_LO +: 6]);
    lower_attr.hier_perm_disable = ctrl_q[htc_pkg::POS_LOWER_HPD];
    lower_attr.walk_disable      = ctrl_q[htc_pkg::POS_LOWER_EPD];
    lower_attr.top_byte_ignore   = ctrl_q[htc_pkg::POS_LOWER_TBI];
  end

  // ==========================================================
  // Regime-wide controls
  logic [5:0] pa_bits;

  // Physical size decode, reserved codes as widest
  always_comb begin
    case (intermediate_phys_size)
      htc_pkg::IPS_32: pa_bits = htc_pkg::PA_BITS_32;
      htc_pkg::IPS_36: pa_bits = htc_pkg::PA_BITS_36;
      htc_pkg::IPS_40: pa_bits = htc_pkg::PA_BITS_40;
      htc_pkg::IPS_42: pa_bits = htc_pkg::PA_BITS_42;
      htc_pkg::IPS_44: pa_bits = htc_pkg::PA_BITS_44;
      default:         pa_bits = htc_pkg::PA_BITS_48;
    endcase
  end

  // Access-flag and dirty-state controls gated by the host layout select; ASID width and PA size are not
  always_comb begin
    regime_o.access_flag_update_en = host_extension_ctrl_i &
      ctrl_q[htc_pkg::POS_AF_EN];
    regime_o.dirty_state_hw_en = host_extension_ctrl_i &
      ctrl_q[htc_pkg::POS_DIRTY_EN] & ctrl_q[htc_pkg::POS_AF_EN];
    regime_o.wide_asid = ctrl_q[htc_pkg::POS_ID_WIDTH];
    regime_o.pa_bits   = pa_bits;
  end

  // ==========================================================
  // Active ASID for TLB allocation and matching
  logic [15:0] asid_sel;

  always_comb begin
    asid_sel = ctrl_q[htc_pkg::POS_ASID_SEL] ? upper_asid_i
                                             : lower_asid_i;
    active_asid_o = asid_sel;
    if (!ctrl_q[htc_pkg::POS_ID_WIDTH]) begin
      active_asid_o[htc_pkg::ASID_W-1:htc_pkg::ASID_NARROW] = 8'h00;
    end
  end

  // ==========================================================
  // Lookup stage: region select, tag strip, walk or fault
  logic        done_q;
  logic        done_d;
  logic        upper_q;
  logic        upper_d;
  logic        walk_q;
  logic        walk_d;
  logic        fault_q;
  logic        fault_d;
  logic [63:0] match_q;
  logic [63:0] match_d;
  htc_pkg::htc_walk_attr_type attr_q;
  htc_pkg::htc_walk_attr_type attr_d;

  // Tag ignore applies with or without the regime enabled
  always_comb begin
    upper_d = lookup_addr_i[htc_pkg::TAG_SEL_BIT];
    attr_d  = upper_d ? upper_attr : lower_attr;
    match_d = lookup_addr_i;
    if (attr_d.top_byte_ignore) begin
      match_d[htc_pkg::TAG_HI:htc_pkg::TAG_LO] =
        {8{upper_d}};
    end
    done_d  = lookup_valid_i & host_extension_ctrl_i;
    walk_d  = done_d & lookup_miss_i & !attr_d.walk_disable;
    fault_d = done_d & lookup_miss_i & attr_d.walk_disable;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      done_q  <= 1'b0;
      upper_q <= 1'b0;
      walk_q  <= 1'b0;
      fault_q <= 1'b0;
      match_q <= '0;
      attr_q  <= '0;
    end else begin
      done_q  <= done_d;
      upper_q <= upper_d;
      walk_q  <= walk_d;
      fault_q <= fault_d;
      match_q <= match_d;
      attr_q  <= attr_d;
    end
  end

  assign lookup_done_o  = done_q;
  assign lookup_upper_o = upper_q;
  assign walk_req_o     = walk_q;
  assign trans_fault_o  = fault_q;
  assign match_addr_o   = match_q;
  assign walk_attr_o    = attr_q;

  // ==========================================================
  // PC load fixup, independent of regime enable
  logic [63:0] pc_fixed;
  logic        pc_load_q;
  logic        pc_load_d;
  logic [63:0] pc_value_q;
  logic [63:0] pc_value_d;

  htc_pc_tag_fix u_pc_fix (
    .target_i    (pc_target_i),
    .lower_tbi_i (ctrl_q[htc_pkg::POS_LOWER_TBI]),
    .upper_tbi_i (ctrl_q[htc_pkg::POS_UPPER_TBI]),
    .pc_value_o  (pc_fixed)
  );

  // Hold the last fixed value between loads
  always_comb begin
    pc_load_d  = pc_load_i;
    pc_value_d = pc_load_i ? pc_fixed : pc_value_q;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_load_q  <= 1'b0;
      pc_value_q <= '0;
    end else begin
      pc_load_q  <= pc_load_d;
      pc_value_q <= pc_value_d;
    end
  end

  assign pc_load_o  = pc_load_q;
  assign pc_value_o = pc_value_q;

endmodule

`default_nettype wire

/* File: tb/htc_ctrl_asserts.sv */
// Concurrent checks on the host translation control ports
`timescale 1ns/10ps
`default_nettype none

module htc_ctrl_chk (
  input wire logic                    mclk_i,         // Clock
  input wire logic                    reset_i,        // Reset
  input wire logic                    host_extension_ctrl_i, // Host
  input wire logic                    sreg_wr_i,      // Write
  input wire logic [63:0]             sreg_wdata_i,   // Write data
  input wire logic [63:0]             sreg_rdata_o,   // Register
  input wire logic [15:0]             lower_asid_i,   // Lower ASID
  input wire logic [15:0]             upper_asid_i,   // Upper ASID
  input wire logic [15:0]             active_asid_o,  // Active ASID
  input wire logic                    lookup_valid_i, // Lookup
  input wire logic [63:0]             lookup_addr_i,  // Address
  input wire logic                    lookup_miss_i,  // Miss
  input wire logic                    lookup_done_o,  // Done
  input wire logic                    lookup_upper_o, // Region
  input wire logic [63:0]             match_addr_o,   // Match address
  input wire logic                    walk_req_o,     // Walk
  input wire logic                    trans_fault_o,  // Fault
  input wire htc_pkg::htc_regime_type regime_o,       // Regime
  input wire logic                    pc_load_i,      // PC load
  input wire logic [63:0]             pc_target_i,    // PC target
  input wire logic                    pc_load_o,      // PC strobe
  input wire logic [63:0]             pc_value_o      // PC value
);
  default clocking cb @(posedge mclk_i);
  endclocking

  // High through the edge on which reset is let go
  logic rst_tail_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rst_tail_q <= 1'b1;
    end else begin
      rst_tail_q <= 1'b0;
    end
  end
  default disable iff (reset_i || rst_tail_q);

  // ==========================================================
  // Expected values
  logic [63:0] r;
  logic        up_sel;
  logic        walk_off;
  logic [63:0] exp_match;
  logic [63:0] exp_pc;
  logic [15:0] exp_asid;
  assign r = sreg_rdata_o;

  // Tag fixups, walk gating and ASID choice from the held register
  always_comb begin
    up_sel = lookup_addr_i[55];
    walk_off = up_sel ? r[23] : r[7];
    exp_match = lookup_addr_i;
    if (up_sel ? r[38] : r[37]) begin
      exp_match[63:56] = {8{up_sel}};
    end
    exp_pc = pc_target_i;
    if (pc_target_i[55] ? r[38] : r[37]) begin
      exp_pc[63:56] = {8{pc_target_i[55]}};
    end
    exp_asid = r[22] ? upper_asid_i : lower_asid_i;
    if (!r[36]) begin
      exp_asid[15:8] = 8'h00;
    end
  end

  // ==========================================================
  // Sequences
  sequence s_lookup;
    lookup_valid_i && host_extension_ctrl_i;
  endsequence
  sequence s_miss_off;
    s_lookup ##0 (lookup_miss_i && walk_off);
  endsequence
  sequence s_miss_on;
    s_lookup ##0 (lookup_miss_i && !walk_off);
  endsequence

  // ==========================================================
  // Assertions
  chk_write_back: assert property (sreg_wr_i |=>
    r == ($past(sreg_wdata_i) & htc_pkg::WRITE_MASK))
    else $error("readback is not the masked write");
  chk_reg_hold: assert property (!sreg_wr_i |=> $stable(r))
    else $error("register changed without a write");
  chk_reserved_zero: assert property (
    (r & ~htc_pkg::WRITE_MASK) == 64'h0000_0000_0000_0000)
    else $error("reserved bit reads as one");
  chk_lookup_done: assert property (s_lookup |=> lookup_done_o)
    else $error("lookup not answered");
  chk_lookup_refused: assert property (
    !(lookup_valid_i && host_extension_ctrl_i) |=>
    !(lookup_done_o || walk_req_o || trans_fault_o))
    else $error("answer without accepted lookup");
  chk_walk_fault: assert property (
    s_miss_off |=> trans_fault_o && !walk_req_o)
    else $error("disabled walk did not fault");
  chk_walk_start: assert property (
    s_miss_on |=> walk_req_o && !trans_fault_o)
    else $error("enabled walk not started");
  chk_hit_quiet: assert property (
    s_lookup ##0 !lookup_miss_i |=> !(walk_req_o || trans_fault_o))
    else $error("walk or fault on a hit");
  chk_tag_match: assert property (s_lookup |=>
    match_addr_o == $past(exp_match) && lookup_upper_o == $past(up_sel))
    else $error("match address tag handling wrong");
  chk_active_asid: assert property (active_asid_o == exp_asid)
    else $error("active ASID wrong");
  chk_regime_flags: assert property (
    regime_o.access_flag_update_en == (r[39] && host_extension_ctrl_i) &&
    regime_o.dirty_state_hw_en == (r[40] && r[39] && host_extension_ctrl_i)
    && regime_o.wide_asid == r[36])
    else $error("regime flags wrong");
  chk_pc_fix: assert property (
    pc_load_i |=> pc_load_o && pc_value_o == $past(exp_pc))
    else $error("PC top byte fixup wrong");
  chk_pc_hold: assert property (
    !pc_load_i |=> !pc_load_o && $stable(pc_value_o))
    else $error("PC value moved without a load");
endmodule

bind htc_ctrl htc_ctrl_chk u_htc_ctrl_chk (
  .mclk_i(mclk_i), .reset_i(reset_i),
  .host_extension_ctrl_i(host_extension_ctrl_i),
  .sreg_wr_i(sreg_wr_i), .sreg_wdata_i(sreg_wdata_i),
  .sreg_rdata_o(sreg_rdata_o), .lower_asid_i(lower_asid_i),
  .upper_asid_i(upper_asid_i), .active_asid_o(active_asid_o),
  .lookup_valid_i(lookup_valid_i), .lookup_addr_i(lookup_addr_i),
  .lookup_miss_i(lookup_miss_i), .lookup_done_o(lookup_done_o),
  .lookup_upper_o(lookup_upper_o), .match_addr_o(match_addr_o),
  .walk_req_o(walk_req_o), .trans_fault_o(trans_fault_o),
  .regime_o(regime_o), .pc_load_i(pc_load_i),
  .pc_target_i(pc_target_i), .pc_load_o(pc_load_o),
  .pc_value_o(pc_value_o)
);
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the host translation control block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ==========================================================
  // Signals and bookkeeping
  localparam logic [63:0] RW_BITS = 64'h0000_07FF_FFFF_FFFF &
    ~64'h0000_0008_0000_0000 & ~64'h0000_0000_0000_0040;
  logic        mclk_i, reset_i, host_extension_ctrl_i, sreg_wr_i;
  logic        lookup_valid_i, lookup_miss_i, pc_load_i;
  logic        lookup_done_o, lookup_upper_o, walk_req_o;
  logic        trans_fault_o, pc_load_o;
  logic [63:0] sreg_wdata_i, lookup_addr_i, pc_target_i, sreg_rdata_o;
  logic [63:0] match_addr_o, pc_value_o, shadow, v, a;
  logic [15:0] lower_asid_i, upper_asid_i, active_asid_o, ea;
  htc_pkg::htc_walk_attr_type walk_attr_o;
  htc_pkg::htc_regime_type    regime_o;
  int          err_total, n_tests, cycles;

  htc_ctrl u_htc_ctrl (
    .mclk_i(mclk_i), .reset_i(reset_i),
    .host_extension_ctrl_i(host_extension_ctrl_i),
    .sreg_wr_i(sreg_wr_i), .sreg_wdata_i(sreg_wdata_i),
    .sreg_rdata_o(sreg_rdata_o), .lower_asid_i(lower_asid_i),
    .upper_asid_i(upper_asid_i), .active_asid_o(active_asid_o),
    .lookup_valid_i(lookup_valid_i), .lookup_addr_i(lookup_addr_i),
    .lookup_miss_i(lookup_miss_i), .lookup_done_o(lookup_done_o),
    .lookup_upper_o(lookup_upper_o), .match_addr_o(match_addr_o),
    .walk_req_o(walk_req_o), .trans_fault_o(trans_fault_o),
    .walk_attr_o(walk_attr_o), .regime_o(regime_o),
    .pc_load_i(pc_load_i), .pc_target_i(pc_target_i),
    .pc_load_o(pc_load_o), .pc_value_o(pc_value_o)
  );

  // ==========================================================
  // Expectations
  function automatic htc_pkg::htc_walk_attr_type exp_attr(
    input logic [63:0] r, input logic up);
    logic [2:0] g;
    logic [1:0] s;
    htc_pkg::htc_walk_attr_type t;
    g = {up, up ? r[31:30] : r[15:14]};
    s = up ? r[29:28] : r[13:12];
    t.granule = htc_pkg::HTC_GRAN_4K;
    if (g == 3'h1 || g == 3'h7) t.granule = htc_pkg::HTC_GRAN_64K;
    if (g == 3'h2 || g == 3'h5) t.granule = htc_pkg::HTC_GRAN_16K;
    t.share = (s == 2'h2) ? htc_pkg::HTC_SHARE_OUTER :
      (s == 2'h3) ? htc_pkg::HTC_SHARE_INNER : htc_pkg::HTC_SHARE_NON;
    t.outer_cache = htc_pkg::htc_cache_type'(up ? r[27:26] : r[11:10]);
    t.inner_cache = htc_pkg::htc_cache_type'(up ? r[25:24] : r[9:8]);
    t.size_log2 = 7'h40 - {1'b0, up ? r[21:16] : r[5:0]};
    t.hier_perm_disable = up ? r[42] : r[41];
    t.walk_disable = up ? r[23] : r[7];
    t.top_byte_ignore = up ? r[38] : r[37];
    return t;
  endfunction

  function automatic htc_pkg::htc_regime_type exp_regime(
    input logic [63:0] r, input logic e);
    htc_pkg::htc_regime_type t;
    logic [5:0] w[8] = '{6'h20, 6'h24, 6'h28, 6'h2A, 6'h2C, 6'h30,
      6'h30, 6'h30};
    t.access_flag_update_en = r[39] & e;
    t.dirty_state_hw_en = r[40] & r[39] & e;
    t.wide_asid = r[36];
    t.pa_bits = w[r[34:32]];
    return t;
  endfunction

  function automatic logic [63:0] exp_pc(input logic [63:0] t,
    input logic [63:0] r);
    if (t[55] ? r[38] : r[37]) t[63:56] = {8{t[55]}};
    return t;
  endfunction

  // ==========================================================
  // Compare and port tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic write_reg(input logic [63:0] d);
    @(posedge mclk_i);
    sreg_wr_i <= 1'b1;
    sreg_wdata_i <= d;
    lower_asid_i <= 16'($urandom);
    upper_asid_i <= 16'($urandom);
    @(posedge mclk_i);
    sreg_wr_i <= 1'b0;
    #1;
    shadow = d & RW_BITS;
    check(sreg_rdata_o, shadow);
    ea = shadow[22] ? upper_asid_i : lower_asid_i;
    if (!shadow[36]) ea[15:8] = 8'h00;
    check(64'(active_asid_o), 64'(ea));
    check(64'(regime_o), 64'(exp_regime(shadow, host_extension_ctrl_i)));
  endtask

  task automatic lookup(input logic [63:0] ad, input logic miss);
    logic e;
    logic off;
    e = host_extension_ctrl_i;
    off = ad[55] ? shadow[23] : shadow[7];
    @(posedge mclk_i);
    lookup_valid_i <= 1'b1;
    lookup_addr_i <= ad;
    lookup_miss_i <= miss;
    @(posedge mclk_i);
    lookup_valid_i <= 1'b0;
    #1;
    check(64'(lookup_done_o), 64'(e));
    check(64'(walk_req_o), 64'(e & miss & !off));
    check(64'(trans_fault_o), 64'(e & miss & off));
    if (e) check(64'(walk_attr_o), 64'(exp_attr(shadow, ad[55])));
  endtask

  task automatic pc_jump(input logic [63:0] t);
    @(posedge mclk_i);
    pc_load_i <= 1'b1;
    pc_target_i <= t;
    @(posedge mclk_i);
    pc_load_i <= 1'b0;
    #1;
    check(64'(pc_load_o), 64'h0000_0000_0000_0001);
    check(pc_value_o, exp_pc(t, shadow));
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {reset_i, host_extension_ctrl_i} = 2'h3;
    {sreg_wr_i, lookup_valid_i, lookup_miss_i, pc_load_i} = 4'h0;
    {sreg_wdata_i, lookup_addr_i, pc_target_i} = '0;
    {lower_asid_i, upper_asid_i} = '0;
    void'($urandom(32'h0752_0650));
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    check(sreg_rdata_o, 64'h0000_0000_0000_0000);
    // Size codes, all ones, zero, then random register values
    for (int i = 0; i < 48; i++) begin
      v = (i < 8) ? 64'(i) << 32 : {$urandom, $urandom};
      if (i == 8) v = 64'hFFFF_FFFF_FFFF_FFFF;
      if (i == 9) v = 64'h0000_0000_0000_0000;
      write_reg(v);
      a = {$urandom, $urandom};
      lookup(a & ~64'h0080_0000_0000_0000, 1'($urandom));
      lookup(a | 64'h0080_0000_0000_0000, 1'($urandom));
      pc_jump({$urandom, $urandom});
    end
    // Host layout off: lookups refused, tag fixup still applies
    @(posedge mclk_i);
    host_extension_ctrl_i <= 1'b0;
    for (int j = 0; j < 8; j++) begin
      write_reg(64'(j & 3) << 37 | 64'h0000_0180_0000_0000);
      lookup({$urandom, $urandom}, 1'b1);
      pc_jump({$urandom, $urandom} ^ (64'(j >> 2) << 55));
    end
    // Random traffic on every input, with a reset in mid-run
    for (int k = 0; k < 3000; k++) begin
      @(posedge mclk_i);
      sreg_wr_i <= ($urandom % 8) == 0;
      sreg_wdata_i <= {$urandom, $urandom};
      host_extension_ctrl_i <= ($urandom % 8) != 0;
      {lookup_valid_i, lookup_miss_i, pc_load_i} <= 3'($urandom);
      lookup_addr_i <= {$urandom, $urandom};
      pc_target_i <= {$urandom, $urandom};
      {lower_asid_i, upper_asid_i} <= $urandom;
      reset_i <= (k >= 1500 && k < 1503);
    end
    @(posedge mclk_i);
    {sreg_wr_i, lookup_valid_i, pc_load_i} <= 3'h0;
    repeat (2) @(posedge mclk_i);
    finish_test();
  end
endmodule
`default_nettype wire
